//--- hw/ocsr_top.sv
// output clock synchronisation, reset and output code formatting
//
// Overview of operation
// - reset pin accepted any time; output clock then held at a fixed level.
// - held level depends on single/double rate mode and output edge selection.
// - assertion may cut the running output clock short, giving one narrow pulse.
// - release comes with a sampling rising edge; phase aligns on next falling edge.
// - output clock restarts after the normal sampling-to-output latency.
// - results are 8-bit offset binary, 00 at negative and FF at positive full scale.
// - over-range input saturates the code and raises out-of-range while it lasts.
// - full scale follows select pin normally, adjust register in extended mode.
// - double rate gives a word per edge; single rate one per period on chosen edge.
// - out-of-range stays active while either bus result falls outside 00 to FF.
`timescale 1ns/100ps
module ocsr_top
(
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins from outside the mclk domain
  input wire logic sampling_clock,
  input wire logic output_clock_reset,
  input wire logic full_scale_select,
  input wire logic output_edge_select,
  input wire logic [ocsr_pkg::SAMPLE_W-1:0] sample_in,
  // from the calibration engine, same clock
  input wire logic calibration_active,
  // outputs to capture logic
  output logic output_data_clock,
  output logic [7:0] data_bus_a,
  output logic [7:0] data_bus_b,
  output logic out_of_range,
  output logic irq
);

  // signed sample scaled and offset to an 8-bit code; bit 8 flags clipping
  function automatic logic [8:0] encode_sample
  (
    input logic signed [ocsr_pkg::SAMPLE_W-1:0] sample,
    input logic [ocsr_pkg::GAIN_W-1:0] gain
  );
    logic signed [ocsr_pkg::SAMPLE_W+ocsr_pkg::GAIN_W:0] product;
    logic signed [ocsr_pkg::SAMPLE_W+ocsr_pkg::GAIN_W:0] code;
    logic [8:0] result;
    product = sample * $signed({1'b0, gain});
    code = (product >>> ocsr_pkg::GAIN_SHIFT) + $signed({1'b0, ocsr_pkg::CODE_MID});
    if (code < 0)
    begin
      result = {1'b1, ocsr_pkg::CODE_MIN};
    end
    else if (code > $signed({1'b0, ocsr_pkg::CODE_MAX}))
    begin
      result = {1'b1, ocsr_pkg::CODE_MAX};
    end
    else
    begin
      result = {1'b0, code[7:0]};
    end
    return result;
  endfunction : encode_sample

  ocsr_pkg::ocsr_cfg_t cfg;
  ocsr_pkg::ocsr_state_t state;
  ocsr_pkg::ocsr_word_t word;
  logic [ocsr_pkg::EV_COUNT-1:0] irq_status;
  logic [ocsr_pkg::EV_COUNT-1:0] irq_enable;
  logic [ocsr_pkg::EV_COUNT-1:0] irq_clear;
  logic [ocsr_pkg::EV_COUNT-1:0] events;

  // two-flop synchronisers; the first stage is read by the second only
  logic sclk_s1, sclk_s2, sclk_s3;
  logic rstpin_s1, rstpin_s2;
  logic fsr_s1, fsr_s2;
  logic edge_s1, edge_s2;
  logic [ocsr_pkg::SAMPLE_W-1:0] sample_s1, sample_s2;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      rstpin_s1 <= 1'b0;
      rstpin_s2 <= 1'b0;
      fsr_s1 <= 1'b0;
      fsr_s2 <= 1'b0;
      edge_s1 <= 1'b0;
      edge_s2 <= 1'b0;
      sample_s1 <= '0;
      sample_s2 <= '0;
    end
    else
    begin
      sclk_s1 <= sampling_clock;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      rstpin_s1 <= output_clock_reset;
      rstpin_s2 <= rstpin_s1;
      fsr_s1 <= full_scale_select;
      fsr_s2 <= fsr_s1;
      edge_s1 <= output_edge_select;
      edge_s2 <= edge_s1;
      // the sample is stable around the sampling edge, so bitwise sync is safe here
      sample_s1 <= sample_in;
      sample_s2 <= sample_s1;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign sclk_fall = ~sclk_s2 & sclk_s3;

  // effective mode: in normal control mode the register has no say
  logic eff_drd;
  logic eff_edge;
  logic hold_level;
  logic [ocsr_pkg::GAIN_W-1:0] gain;
  assign eff_drd = cfg.extended_mode ? cfg.double_rate_disable : ocsr_pkg::CTL_DRD_RST;
  assign eff_edge = cfg.extended_mode ? cfg.output_edge_select : edge_s2;
  // held low when the next edge that carries data is rising, high when it is falling
  assign hold_level = eff_drd & ~eff_edge;
  // linear approximation of the inverse range law; accurate within a few percent
  assign gain = cfg.extended_mode
    ? ocsr_pkg::GAIN_EXT_BASE - {3'h0, cfg.fs_adjust[8:2]}
    : (fsr_s2 ? ocsr_pkg::GAIN_FSR_HIGH : ocsr_pkg::GAIN_FSR_LOW);

  // apb slave: one wait state, answer registered
  logic apb_access;
  logic apb_write;
  assign apb_access = psel & penable & ~pready;
  assign apb_write = psel & penable & pready & pwrite;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= apb_access;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (apb_access)
      begin
        unique case (paddr)
          ocsr_pkg::REG_CONTROL:
          begin
            prdata[ocsr_pkg::CTL_EXTENDED_BIT] <= cfg.extended_mode;
            prdata[ocsr_pkg::CTL_DRD_BIT] <= cfg.double_rate_disable;
            prdata[ocsr_pkg::CTL_EDGE_BIT] <= cfg.output_edge_select;
            prdata[ocsr_pkg::CTL_ADJ_MSB:ocsr_pkg::CTL_ADJ_LSB] <= cfg.fs_adjust;
          end
          ocsr_pkg::REG_STATE:
          begin
            prdata[1:0] <= state;
            prdata[2] <= output_data_clock;
            prdata[3] <= calibration_active;
          end
          ocsr_pkg::REG_IRQ_STATUS: prdata[ocsr_pkg::EV_COUNT-1:0] <= irq_status;
          ocsr_pkg::REG_IRQ_ENABLE: prdata[ocsr_pkg::EV_COUNT-1:0] <= irq_enable;
          ocsr_pkg::REG_IRQ_CLEAR: prdata <= 32'h00000000;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cfg.extended_mode <= ocsr_pkg::CTL_EXTENDED_RST;
      cfg.double_rate_disable <= ocsr_pkg::CTL_DRD_RST;
      cfg.output_edge_select <= ocsr_pkg::CTL_EDGE_RST;
      cfg.fs_adjust <= ocsr_pkg::CTL_ADJ_RST;
    end
    else if (apb_write && paddr == ocsr_pkg::REG_CONTROL)
    begin
      cfg.extended_mode <= pwdata[ocsr_pkg::CTL_EXTENDED_BIT];
      cfg.double_rate_disable <= pwdata[ocsr_pkg::CTL_DRD_BIT];
      cfg.output_edge_select <= pwdata[ocsr_pkg::CTL_EDGE_BIT];
      cfg.fs_adjust <= pwdata[ocsr_pkg::CTL_ADJ_MSB:ocsr_pkg::CTL_ADJ_LSB];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_enable <= ocsr_pkg::IRQ_ENABLE_RST;
    end
    else if (apb_write && paddr == ocsr_pkg::REG_IRQ_ENABLE)
    begin
      irq_enable <= pwdata[ocsr_pkg::EV_COUNT-1:0];
    end
  end

  assign irq_clear = (apb_write && paddr == ocsr_pkg::REG_IRQ_CLEAR)
    ? pwdata[ocsr_pkg::EV_COUNT-1:0] : '0;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_status <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq_status <= (irq_status & ~irq_clear) | events;
      irq <= |(((irq_status & ~irq_clear) | events) & irq_enable);
    end
  end

  // output clock control
  logic [3:0] delay_count;
  logic word_phase;
  logic [7:0] first_code;
  logic first_clip;
  logic [8:0] enc;
  logic word_strobe;
  assign enc = encode_sample(sample_s2, gain);
  assign word_strobe = (state == ocsr_pkg::OCSR_RUN) && sclk_rise && word_phase;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= ocsr_pkg::OCSR_RUN;
      delay_count <= 4'h0;
    end
    else if (rstpin_s2)
    begin
      // taken at once whatever the sampling clock is doing
      state <= ocsr_pkg::OCSR_HOLD;
      delay_count <= 4'h0;
    end
    else
    begin
      unique case (state)
        ocsr_pkg::OCSR_RUN: state <= ocsr_pkg::OCSR_RUN;
        ocsr_pkg::OCSR_HOLD: state <= ocsr_pkg::OCSR_ALIGN;
        ocsr_pkg::OCSR_ALIGN:
        begin
          if (sclk_fall)
          begin
            state <= ocsr_pkg::OCSR_DELAY;
            delay_count <= 4'h0;
          end
        end
        ocsr_pkg::OCSR_DELAY:
        begin
          if (sclk_rise)
          begin
            if (delay_count == ocsr_pkg::PIPE_LATENCY - 4'h1)
            begin
              state <= ocsr_pkg::OCSR_RUN;
            end
            delay_count <= delay_count + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      output_data_clock <= 1'b0;
      word_phase <= 1'b0;
    end
    else if (state != ocsr_pkg::OCSR_RUN || rstpin_s2)
    begin
      // forcing mid-period may leave one short high or low pulse
      output_data_clock <= hold_level;
      word_phase <= 1'b0;
    end
    else if (sclk_rise)
    begin
      word_phase <= ~word_phase;
      if (!eff_drd)
      begin
        if (word_phase)
        begin
          output_data_clock <= ~output_data_clock;
        end
      end
      else
      begin
        output_data_clock <= word_phase ? eff_edge : ~eff_edge;
      end
    end
  end

  // demux: two consecutive samples form one word pair on the two buses
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      first_code <= ocsr_pkg::CODE_MID;
      first_clip <= 1'b0;
      word <= '0;
      out_of_range <= 1'b0;
    end
    else
    begin
      if (sclk_rise && !word_phase)
      begin
        first_code <= enc[7:0];
        first_clip <= enc[8];
      end
      if (word_strobe)
      begin
        word.bus_a <= first_code;
        word.bus_b <= enc[7:0];
        out_of_range <= first_clip | enc[8];
      end
    end
  end

  assign data_bus_a = word.bus_a;
  assign data_bus_b = word.bus_b;

  // events
  logic rstpin_d;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rstpin_d <= 1'b0;
    end
    else
    begin
      rstpin_d <= rstpin_s2;
    end
  end

  always_comb
  begin
    events = '0;
    events[ocsr_pkg::EV_RESET_SEEN] = rstpin_s2 & ~rstpin_d;
    events[ocsr_pkg::EV_ALIGNED] = (state == ocsr_pkg::OCSR_DELAY) && sclk_rise
      && (delay_count == ocsr_pkg::PIPE_LATENCY - 4'h1) && !rstpin_s2;
    events[ocsr_pkg::EV_OUT_OF_RANGE] = word_strobe & (first_clip | enc[8]);
    // a reset during calibration may spoil it; flag it so software can recalibrate
    events[ocsr_pkg::EV_RESET_IN_CAL] = rstpin_s2 & ~rstpin_d & calibration_active;
  end

endmodule : ocsr_top

//--- shared/ocsr_pkg.sv
// shared constants and types for the output clock sync and reset block
package ocsr_pkg;

  // register byte offsets
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h18;

  // control register fields
  localparam int CTL_EXTENDED_BIT = 0;
  localparam int CTL_DRD_BIT = 1;
  localparam int CTL_EDGE_BIT = 2;
  localparam int CTL_ADJ_LSB = 16;
  localparam int CTL_ADJ_MSB = 24;

  // reset values
  localparam logic CTL_EXTENDED_RST = 1'h0;
  localparam logic CTL_DRD_RST = 1'h0;
  localparam logic CTL_EDGE_RST = 1'h0;
  localparam logic [8:0] CTL_ADJ_RST = 9'h100;
  localparam logic [3:0] IRQ_ENABLE_RST = 4'h0;

  // interrupt event bit positions
  localparam int EV_RESET_SEEN = 0;
  localparam int EV_ALIGNED = 1;
  localparam int EV_OUT_OF_RANGE = 2;
  localparam int EV_RESET_IN_CAL = 3;
  localparam int EV_COUNT = 4;

  // conversion: code = 128 + (sample * gain) >>> GAIN_SHIFT, gain in 1/2048 steps
  localparam int SAMPLE_W = 12;
  localparam int GAIN_W = 10;
  localparam int GAIN_SHIFT = 11;
  localparam logic [GAIN_W-1:0] GAIN_FSR_HIGH = 10'h100;
  localparam logic [GAIN_W-1:0] GAIN_FSR_LOW = 10'h155;
  localparam logic [GAIN_W-1:0] GAIN_EXT_BASE = 10'h140;
  localparam logic [7:0] CODE_MID = 8'h80;
  localparam logic [7:0] CODE_MIN = 8'h00;
  localparam logic [7:0] CODE_MAX = 8'hFF;

  // sampling-clock to output-clock latency, in sampling clock cycles
  localparam logic [3:0] PIPE_LATENCY = 4'h4;

  // timing
  localparam int MCLK_MHZ = 100;

  typedef struct packed {
    logic [8:0] fs_adjust;
    logic output_edge_select;
    logic double_rate_disable;
    logic extended_mode;
  } ocsr_cfg_t;

  typedef struct packed {
    logic [7:0] bus_a;
    logic [7:0] bus_b;
  } ocsr_word_t;

  typedef enum logic [1:0] {
    OCSR_RUN,
    OCSR_HOLD,
    OCSR_ALIGN,
    OCSR_DELAY
  } ocsr_state_t;

endpackage : ocsr_pkg

//--- verif/ocsr_chk.sv
// port assertions for the output clock sync block
`timescale 1ns/100ps
module ocsr_chk
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic output_clock_reset,
  input wire logic output_data_clock,
  input wire logic [7:0] data_bus_a,
  input wire logic [7:0] data_bus_b,
  input wire logic out_of_range,
  input wire logic irq
);
  logic ext, drd, edg;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // mirror of the mode bits, taken at the same edge the write lands
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      {edg, drd, ext} <= 3'h0;
    end
    else if (psel && penable && pready && pwrite && paddr == ocsr_pkg::REG_CONTROL)
    begin
      {edg, drd, ext} <= pwdata[2:0];
    end
  end
  sequence s_acc; psel && penable && !pready; endsequence
  sequence s_rel; $fell(output_clock_reset); endsequence
  property p_ans; s_acc |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer after one wait state");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held too long");
  property p_err; pslverr |-> pready && paddr != ocsr_pkg::REG_CONTROL; endproperty
  a_err: assert property (p_err) else $error("bad error response");
  property p_hold; output_clock_reset [*6] |-> output_data_clock == (ext && drd && !edg); endproperty
  a_hold: assert property (p_hold) else $error("output clock not at hold level");
  // falling edge, four latency rises, then the second rise in run; two mclk of sync slack each way
  property p_restart; s_rel |=> $stable(output_data_clock) [*8] ##[41:45] $changed(output_data_clock); endproperty
  a_restart: assert property (p_restart) else $error("output clock restart out of window");
  property p_clip; out_of_range |-> data_bus_a inside {8'h00, 8'hFF} || data_bus_b inside {8'h00, 8'hFF}; endproperty
  a_clip: assert property (p_clip) else $error("out of range without end code");
  property p_word; $changed({data_bus_a, data_bus_b}) |-> $changed(output_data_clock); endproperty
  a_word: assert property (p_word) else $error("word moved off a clock edge");
  property p_mask; pready && pwrite && paddr == ocsr_pkg::REG_IRQ_ENABLE && pwdata == 32'h0 |-> ##2 !irq; endproperty
  a_mask: assert property (p_mask) else $error("irq not masked");
endmodule : ocsr_chk
bind ocsr_top ocsr_chk ocsr_chk_i (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .output_clock_reset, .output_data_clock, .data_bus_a, .data_bus_b, .out_of_range, .irq);

//--- verif/ocsr_far.sv
// far side model: sampling clock, sync controller and sample source
`timescale 1ns/100ps
module ocsr_far
(
  output logic sampling_clock,
  output logic output_clock_reset,
  output logic [ocsr_pkg::SAMPLE_W-1:0] sample_in,
  input wire logic calibration_active,
  input wire logic rst_req,
  input wire logic [ocsr_pkg::SAMPLE_W-1:0] smp
);
  initial
  begin
    sampling_clock = 1'h0;
    output_clock_reset = 1'h0;
    sample_in = 12'h000;
    #3;
    forever #40 sampling_clock = ~sampling_clock;
  end
  // raised with no regard to either clock, so a cut-short pulse can occur
  always @(posedge rst_req)
    if (!calibration_active)
      output_clock_reset <= 1'h1;
  always @(posedge sampling_clock)
    if (!rst_req)
      output_clock_reset <= 1'h0;
  // moves on the falling edge so it is settled around each rising edge
  always @(negedge sampling_clock)
    sample_in <= smp;
endmodule : ocsr_far

//--- verif/ocsr_tb_top.sv
// self-checking bench for the output clock sync block
`timescale 1ns/100ps
module ocsr_tb_top;
  localparam logic [11:0] CS[7] = '{12'hC00, 12'hE00, 12'h000, 12'h200, 12'h3F8, 12'h7FF, 12'h800};
  localparam logic [7:0] CC[7] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'hFF, 8'hFF, 8'h00};
  localparam logic [31:0] HC[4] = '{32'h0100_0002, 32'h0100_0003, 32'h0100_0007, 32'h0100_0001};
  localparam logic HL[4] = '{1'h0, 1'h1, 1'h0, 1'h0};
  logic mclk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e;
  logic full_scale_select = 1'h1, output_edge_select = 1'h0, calibration_active = 1'h0, rst_req = 1'h0;
  logic [7:0] paddr = 8'h00, data_bus_a, data_bus_b;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [ocsr_pkg::SAMPLE_W-1:0] smp = 12'h000, sample_in;
  logic pready, pslverr, sampling_clock, output_clock_reset, output_data_clock, out_of_range, irq;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  ocsr_top ocsr_top_i (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sampling_clock, .output_clock_reset, .full_scale_select, .output_edge_select, .sample_in,
    .calibration_active, .output_data_clock, .data_bus_a, .data_bus_b, .out_of_range, .irq);
  ocsr_far ocsr_far_i (.sampling_clock, .output_clock_reset, .sample_in, .calibration_active, .rst_req, .smp);
  always #5 mclk = ~mclk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20)
      chk("apb_wait", 32'h1, 32'h0);
  endtask : apb
  // fixed settle time: several word pairs pass the pipeline
  task automatic conv(input logic [11:0] s, input logic [7:0] exp, input logic oor);
    @(posedge mclk);
    smp <= s;
    repeat (200) @(posedge mclk);
    chk("bus_a", data_bus_a, exp);
    chk("bus_b", data_bus_b, exp);
    chk("out_of_range", out_of_range, oor);
  endtask : conv
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    rst <= 1'h0;
    apb(1'h0, ocsr_pkg::REG_CONTROL, 32'h0);
    chk("control_rst", q, 32'h0100_0000);
    apb(1'h0, ocsr_pkg::REG_IRQ_ENABLE, 32'h0);
    chk("enable_rst", q, 32'h0);
    apb(1'h0, 8'h20, 32'h0);
    chk("unmapped", e, 32'h1);
    // the output clock runs free from reset; read the state in a low half period
    @(negedge output_data_clock);
    calibration_active <= 1'h1;
    apb(1'h0, ocsr_pkg::REG_STATE, 32'h0);
    chk("state", q[3:0], 32'h8);
    calibration_active <= 1'h0;
    for (int i = 0; i < 7; i++)
      conv(CS[i], CC[i], i > 4);
    apb(1'h0, ocsr_pkg::REG_IRQ_STATUS, 32'h0);
    chk("oor_event", q[3:0], 32'h4);
    full_scale_select <= 1'h0;
    conv(12'h200, 8'hD5, 1'h0);
    apb(1'h1, ocsr_pkg::REG_CONTROL, 32'h1);
    conv(12'h200, 8'hD0, 1'h0);
    // same code in every mode below, so no word moves while a mode switch reshapes the clock
    full_scale_select <= 1'h1;
    apb(1'h1, ocsr_pkg::REG_IRQ_ENABLE, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'h1, ocsr_pkg::REG_CONTROL, HC[i]);
      apb(1'h1, ocsr_pkg::REG_IRQ_CLEAR, 32'hF);
      rst_req <= 1'h1;
      repeat (20) @(posedge mclk);
      chk("hold_level", output_data_clock, HL[i]);
      chk("irq_up", irq, 32'h1);
      rst_req <= 1'h0;
      repeat (150) @(posedge mclk);
      apb(1'h0, ocsr_pkg::REG_IRQ_STATUS, 32'h0);
      chk("aligned", q[3:0], 32'h3);
    end
    apb(1'h1, ocsr_pkg::REG_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge mclk);
    chk("irq_masked", irq, 32'h0);
    apb(1'h1, ocsr_pkg::REG_IRQ_ENABLE, 32'h3);
    repeat (2) @(posedge mclk);
    chk("irq_unmasked", irq, 32'h1);
    apb(1'h1, ocsr_pkg::REG_IRQ_CLEAR, 32'hF);
    repeat (2) @(posedge mclk);
    chk("irq_cleared", irq, 32'h0);
    apb(1'h0, ocsr_pkg::REG_IRQ_CLEAR, 32'h0);
    chk("clear_reads_zero", q, 32'h0);
    summarize();
  end
endmodule : ocsr_tb_top
